/* File: mtch_consts.svh */
`ifndef MTCH_CONSTS_SVH
`define MTCH_CONSTS_SVH

// ----------------------------------------------------------------------
// register addresses on the two address inputs {A1,A0}
// ----------------------------------------------------------------------
`define MTCH_ADDR_DATA 2'h0
`define MTCH_ADDR_CMD 2'h1
`define MTCH_ADDR_CTRL 2'h2
`define MTCH_ADDR_MODE 2'h3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MTCH_CMD_EOP 5
`define MTCH_CMD_ENV 4
`define MTCH_ST_IRQ 7
`define MTCH_ST_BUFFER_FREE_FLAG 6
`define MTCH_ST_DET 0
`define MTCH_MODE_IEN 7
`define MTCH_MODE_TXSEL 6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MTCH_MODE_RST 8'h00
`define MTCH_CTRL_RST 8'h00
`define MTCH_DATA_RST 8'h00

// ----------------------------------------------------------------------
// task codes (receive name / transmit name share a code)
// ----------------------------------------------------------------------
`define MTCH_TC_NULL 4'h0
`define MTCH_TC_HEAD 4'h1
`define MTCH_TC_HEADBYTES 4'h2
`define MTCH_TC_BLOCK 4'h3
`define MTCH_TC_SYNC_FOUR 4'h4
`define MTCH_TC_SINGLE 4'h5
`define MTCH_TC_LOAD_SCRAM 4'h6
`define MTCH_TC_CANCEL 4'h7
`define MTCH_TC_HEAD_EXACT 4'h9
`define MTCH_TC_SHORT 4'hB
`define MTCH_TC_SYNC_EXACT 4'hC
`define MTCH_TC_PS_BIAS 4'hE
`define MTCH_TC_PS_OSC 4'hF

// ----------------------------------------------------------------------
// byte counts and timing
// ----------------------------------------------------------------------
`define MTCH_BUF_LEN 5'd18
`define MTCH_LEN_HEAD 5'd6
`define MTCH_LEN_FOUR 5'd4
`define MTCH_LEN_ONE 5'd1
`define MTCH_LEN_SHORT 5'd4
`define MTCH_LEN_SYNC 5'd2
`define MTCH_EOP_BITS 3'd3

`endif

/* File: mtch_pkg.sv */
package mtch_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } mtch_bus_t;

    typedef struct packed {
        logic tx;
        logic [3:0] code;
    } mtch_task_t;

    typedef enum logic [3:0] {
        K_NULL = 4'h0,
        K_RX_DATA = 4'h1,
        K_RX_LOAD = 4'h2,
        K_TX_DATA = 4'h3,
        K_TX_SCRAM = 4'h4,
        K_CANCEL = 4'h5,
        K_PS_BIAS = 4'h6,
        K_PS_OSC = 4'h7,
        K_RESV = 4'h8
    } mtch_kind_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_MOVE = 2'b01,
        S_RX_WAIT = 2'b10
    } mtch_state_t;

endpackage : mtch_pkg

/* File: mtch_pair.sv */
`timescale 1ns/1ps
module mtch_pair (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [7:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [7:0] o_data
);
    import mtch_pkg::*;

    logic [7:0] slot0_r, slot0_nxt, slot1_r, slot1_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;
    logic [1:0] widx;

    assign o_ready = (cnt_r != 2'd2);
    assign o_valid = (cnt_r != 2'd0);
    assign o_data = slot0_r;

    always_comb begin
        push = i_valid & o_ready;
        pop = o_valid & i_ready;
        widx = cnt_r - {1'b0, pop};
        slot0_nxt = slot0_r;
        slot1_nxt = slot1_r;
        if (pop) begin
            slot0_nxt = slot1_r;
        end
        if (push) begin
            if (widx == 2'd0) begin
                slot0_nxt = i_data;
            end else begin
                slot1_nxt = i_data;
            end
        end
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            slot0_r <= 8'h00;
            slot1_r <= 8'h00;
            cnt_r <= 2'd0;
        end else begin
            slot0_r <= slot0_nxt;
            slot1_r <= slot1_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule : mtch_pair

/* File: mtch_core.sv */
// Contract
// - eop detector high after >3 bits centred
// - eop detector drops at once off centre
// - envelope detector high on wide level spread
// - status bit0 chosen by detector enables
// - both enabled: env and not eop, both edges
// - dq bits 0,1 show detectors
// - cancel, transmit select, powersave restore dq
// - receive task code decode
// - transmit task code decode, some reserved
// - codes 1110/1111 select powersave depth
// - transmit data tasks take buffer data
// - transmit data task clears buffer free at once
// - move stalls until interleave side has room
// - move done sets free and irq flags
// - receive task waits, fills buffer, then free
// - received byte 0 read first
// - command write-only, reads give status
// - 18-byte buffer behind one stepping port
`timescale 1ns/1ps
`include "mtch_consts.svh"
module mtch_core (
    input wire logic i_clk,
    input wire logic i_reset,
    input mtch_pkg::mtch_bus_t i_bus,
    output logic [7:0] o_rdata,
    output logic o_irq_n,
    input wire logic i_env_pin,
    input wire logic i_eop_pin,
    input wire logic i_bit_tick,
    input wire logic [7:0] i_dq_value,
    output mtch_pkg::mtch_task_t o_task,
    output logic o_task_valid,
    output logic o_ilv_valid,
    input wire logic i_ilv_ready,
    output logic [7:0] o_ilv_data,
    input wire logic i_rx_wvalid,
    input wire logic [7:0] i_rx_wdata,
    input wire logic i_rx_done,
    output logic o_bias_off,
    output logic o_osc_off,
    output logic o_tx_mode,
    output logic [7:0] o_control
);
    import mtch_pkg::*;

    // ------------------------------------------------------------------
    // task decode
    // ------------------------------------------------------------------
    function automatic mtch_kind_t task_kind(input logic tx,
                                             input logic [3:0] code);
        mtch_kind_t k;
        k = K_RESV;
        unique case (code)
            `MTCH_TC_NULL: k = K_NULL;
            `MTCH_TC_HEAD, `MTCH_TC_BLOCK, `MTCH_TC_SYNC_FOUR,
            `MTCH_TC_SINGLE, `MTCH_TC_SHORT:
                k = tx ? K_TX_DATA : K_RX_DATA;
            `MTCH_TC_HEADBYTES, `MTCH_TC_HEAD_EXACT,
            `MTCH_TC_SYNC_EXACT:
                k = tx ? K_RESV : K_RX_DATA;
            `MTCH_TC_LOAD_SCRAM:
                k = tx ? K_TX_SCRAM : K_RX_LOAD;
            `MTCH_TC_CANCEL: k = K_CANCEL;
            `MTCH_TC_PS_BIAS: k = K_PS_BIAS;
            `MTCH_TC_PS_OSC: k = K_PS_OSC;
            default: k = K_RESV;
        endcase
        return k;
    endfunction : task_kind

    // bytes taken from the buffer by a transmit task
    function automatic logic [4:0] tx_len(input logic [3:0] code);
        logic [4:0] n;
        n = `MTCH_LEN_ONE;
        unique case (code)
            `MTCH_TC_HEAD: n = `MTCH_LEN_HEAD;
            `MTCH_TC_BLOCK: n = `MTCH_BUF_LEN;
            `MTCH_TC_SYNC_FOUR: n = `MTCH_LEN_FOUR;
            `MTCH_TC_SHORT: n = `MTCH_LEN_SHORT;
            default: n = `MTCH_LEN_ONE;
        endcase
        return n;
    endfunction : tx_len

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic env_m_r, env_s_r, eop_m_r, eop_s_r;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            env_m_r <= 1'b0;
            env_s_r <= 1'b0;
            eop_m_r <= 1'b0;
            eop_s_r <= 1'b0;
        end else begin
            env_m_r <= i_env_pin;
            env_s_r <= env_m_r;
            eop_m_r <= i_eop_pin;
            eop_s_r <= eop_m_r;
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] buf_r [18];
    logic [7:0] buf_nxt [18];
    logic [4:0] ptr_r, ptr_nxt;
    logic [4:0] len_r, len_nxt;
    mtch_state_t state_r, state_nxt;
    logic [7:0] mode_r, mode_nxt, ctrl_r, ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic env_en_r, env_en_nxt, eop_en_r, eop_en_nxt;
    logic buffer_free_flag_r, buffer_free_flag_nxt, irq_r, irq_nxt;
    logic det_r, det_nxt, dq_det_r, dq_det_nxt;
    logic [2:0] eop_cnt_r, eop_cnt_nxt;
    logic ps_bias_r, ps_bias_nxt, ps_osc_r, ps_osc_nxt;
    mtch_task_t task_r, task_nxt;
    logic task_v_r, task_v_nxt;

    logic rx, env_det, eop_det, det, det_irq;
    logic cmd_wr, acc, push, last_push, fifo_ready;
    mtch_kind_t kind;

    assign rx = ~mode_r[`MTCH_MODE_TXSEL];
    assign env_det = rx & env_s_r;
    assign eop_det = rx & eop_s_r & (eop_cnt_r > `MTCH_EOP_BITS);
    assign cmd_wr = i_bus.wr & (i_bus.addr == `MTCH_ADDR_CMD);
    assign kind = task_kind(~rx, i_bus.wdata[3:0]);
    assign push = (state_r == S_MOVE);
    assign last_push = push & fifo_ready & (ptr_r == len_r - 5'd1);
    // only a free buffer may take a data task; a busy one ignores it
    assign acc = cmd_wr & buffer_free_flag_r & (kind == K_TX_DATA ||
                 kind == K_RX_DATA || kind == K_RX_LOAD);

    always_comb begin
        unique case ({eop_en_r, env_en_r})
            2'b00: det = 1'b0;
            2'b01: det = env_det;
            2'b10: det = eop_det;
            2'b11: det = env_det & ~eop_det;
        endcase
        det_irq = 1'b0;
        if (env_en_r & eop_en_r) begin
            det_irq = det ^ det_r;
        end else if (env_en_r | eop_en_r) begin
            det_irq = det & ~det_r;
        end
    end

    always_comb begin
        buf_nxt = buf_r;
        ptr_nxt = ptr_r;
        len_nxt = len_r;
        state_nxt = state_r;
        mode_nxt = mode_r;
        ctrl_nxt = ctrl_r;
        rdata_nxt = rdata_r;
        env_en_nxt = env_en_r;
        eop_en_nxt = eop_en_r;
        buffer_free_flag_nxt = buffer_free_flag_r;
        irq_nxt = irq_r;
        dq_det_nxt = dq_det_r;
        ps_bias_nxt = ps_bias_r;
        ps_osc_nxt = ps_osc_r;
        task_nxt = task_r;
        task_v_nxt = 1'b0;
        det_nxt = det;
        // centre-hold timer in bit times
        if (!(rx & eop_s_r)) begin
            eop_cnt_nxt = 3'd0;
        end else if (i_bit_tick && eop_cnt_r != 3'd7) begin
            eop_cnt_nxt = eop_cnt_r + 3'd1;
        end else begin
            eop_cnt_nxt = eop_cnt_r;
        end
        // host reads; status read clears the irq flag
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `MTCH_ADDR_DATA: begin
                    rdata_nxt = buf_r[ptr_r];
                    if (buffer_free_flag_r && ptr_r != `MTCH_BUF_LEN - 5'd1) begin
                        ptr_nxt = ptr_r + 5'd1;
                    end
                end
                `MTCH_ADDR_CMD: begin
                    rdata_nxt = {irq_r, buffer_free_flag_r, 5'b0, det_r};
                    irq_nxt = 1'b0;
                end
                `MTCH_ADDR_CTRL: begin
                    rdata_nxt = i_dq_value;
                    if (dq_det_r) begin
                        rdata_nxt[1:0] = {eop_det, env_det};
                    end
                end
                `MTCH_ADDR_MODE: rdata_nxt = 8'h00;
            endcase
        end
        // host writes
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                `MTCH_ADDR_DATA: begin
                    if (buffer_free_flag_r) begin
                        buf_nxt[ptr_r] = i_bus.wdata;
                        if (ptr_r != `MTCH_BUF_LEN - 5'd1) begin
                            ptr_nxt = ptr_r + 5'd1;
                        end
                    end
                end
                `MTCH_ADDR_CMD: begin
                    env_en_nxt = i_bus.wdata[`MTCH_CMD_ENV];
                    eop_en_nxt = i_bus.wdata[`MTCH_CMD_EOP];
                    if (i_bus.wdata[`MTCH_CMD_ENV] |
                        i_bus.wdata[`MTCH_CMD_EOP]) begin
                        dq_det_nxt = 1'b1;
                    end
                    ps_bias_nxt = (kind == K_PS_BIAS) |
                                  (kind == K_PS_OSC);
                    ps_osc_nxt = (kind == K_PS_OSC);
                    if (kind == K_PS_BIAS || kind == K_PS_OSC ||
                        kind == K_CANCEL) begin
                        dq_det_nxt = 1'b0;
                    end
                    if (kind == K_CANCEL) begin
                        state_nxt = S_IDLE;
                        buffer_free_flag_nxt = 1'b1;
                        ptr_nxt = 5'd0;
                    end
                    if (kind == K_CANCEL || kind == K_TX_SCRAM ||
                        acc) begin
                        task_nxt.tx = ~rx;
                        task_nxt.code = i_bus.wdata[3:0];
                        task_v_nxt = 1'b1;
                    end
                    if (acc) begin
                        buffer_free_flag_nxt = 1'b0;
                        ptr_nxt = 5'd0;
                        if (kind == K_TX_DATA) begin
                            state_nxt = S_MOVE;
                            len_nxt = tx_len(i_bus.wdata[3:0]);
                        end else if (kind == K_RX_LOAD) begin
                            state_nxt = S_MOVE;
                            len_nxt = `MTCH_LEN_SYNC;
                        end else begin
                            state_nxt = S_RX_WAIT;
                        end
                    end
                end
                `MTCH_ADDR_CTRL: ctrl_nxt = i_bus.wdata;
                `MTCH_ADDR_MODE: begin
                    mode_nxt = i_bus.wdata;
                    if (i_bus.wdata[`MTCH_MODE_TXSEL]) begin
                        dq_det_nxt = 1'b0;
                    end
                end
            endcase
        end
        // engine side of a running task
        unique case (state_r)
            S_IDLE: ;
            S_MOVE: begin
                // stalls while the interleave side holds back
                if (fifo_ready) begin
                    ptr_nxt = ptr_r + 5'd1;
                end
                if (last_push) begin
                    state_nxt = S_IDLE;
                    buffer_free_flag_nxt = 1'b1;
                    ptr_nxt = 5'd0;
                end
            end
            S_RX_WAIT: begin
                if (i_rx_wvalid && ptr_r != `MTCH_BUF_LEN - 5'd1) begin
                    ptr_nxt = ptr_r + 5'd1;
                end
                if (i_rx_wvalid) begin
                    buf_nxt[ptr_r] = i_rx_wdata;
                end
                if (i_rx_done) begin
                    state_nxt = S_IDLE;
                    buffer_free_flag_nxt = 1'b1;
                    ptr_nxt = 5'd0;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
        // hardware set beats a same-cycle read clear
        if (last_push || (state_r == S_RX_WAIT && i_rx_done) ||
            det_irq) begin
            irq_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < 18; i++) begin
                buf_r[i] <= `MTCH_DATA_RST;
            end
            ptr_r <= 5'd0;
            len_r <= 5'd0;
            state_r <= S_IDLE;
            mode_r <= `MTCH_MODE_RST;
            ctrl_r <= `MTCH_CTRL_RST;
            rdata_r <= 8'h00;
            env_en_r <= 1'b0;
            eop_en_r <= 1'b0;
            buffer_free_flag_r <= 1'b1;
            irq_r <= 1'b0;
            det_r <= 1'b0;
            dq_det_r <= 1'b0;
            eop_cnt_r <= 3'd0;
            ps_bias_r <= 1'b0;
            ps_osc_r <= 1'b0;
            task_r <= '0;
            task_v_r <= 1'b0;
        end else begin
            buf_r <= buf_nxt;
            ptr_r <= ptr_nxt;
            len_r <= len_nxt;
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            env_en_r <= env_en_nxt;
            eop_en_r <= eop_en_nxt;
            buffer_free_flag_r <= buffer_free_flag_nxt;
            irq_r <= irq_nxt;
            det_r <= det_nxt;
            dq_det_r <= dq_det_nxt;
            eop_cnt_r <= eop_cnt_nxt;
            ps_bias_r <= ps_bias_nxt;
            ps_osc_r <= ps_osc_nxt;
            task_r <= task_nxt;
            task_v_r <= task_v_nxt;
        end
    end

    // ------------------------------------------------------------------
    // two-entry buffer toward the interleave side
    // ------------------------------------------------------------------
    mtch_pair u_pair (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_valid(push),
        .o_ready(fifo_ready),
        .i_data(buf_r[ptr_r]),
        .o_valid(o_ilv_valid),
        .i_ready(i_ilv_ready),
        .o_data(o_ilv_data)
    );

    assign o_rdata = rdata_r;
    assign o_irq_n = ~(irq_r & mode_r[`MTCH_MODE_IEN]);
    assign o_task = task_r;
    assign o_task_valid = task_v_r;
    assign o_bias_off = ps_bias_r;
    assign o_osc_off = ps_osc_r;
    assign o_tx_mode = ~rx;
    assign o_control = ctrl_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    eop_rise_a: assert property ($rose(eop_det) |-> eop_cnt_r == 3'd4)
        else $error("eop detector rose early");
    eop_drop_a: assert property ($fell(eop_s_r)
        |-> !eop_det ##1 eop_cnt_r == 3'd0)
        else $error("eop detector held off centre");
    env_tx_a: assert property (!rx |-> !env_det && !eop_det)
        else $error("detector active in transmit");
    stat_off_a: assert property (!env_en_r && !eop_en_r |=> !det_r)
        else $error("status bit0 set with detectors off");
    both_edge_a: assert property (env_en_r && eop_en_r
        && det != det_r |=> irq_r)
        else $error("missed detector edge interrupt");
    dq_restore_a: assert property (cmd_wr && kind == K_CANCEL
        |=> !dq_det_r)
        else $error("quality bits not restored");
    free_clear_a: assert property (acc && kind == K_TX_DATA
        |=> !buffer_free_flag_r && state_r == S_MOVE)
        else $error("buffer free not cleared");
    move_done_a: assert property (last_push && !cmd_wr
        |=> buffer_free_flag_r && irq_r && ptr_r == 5'd0)
        else $error("move completion flags wrong");
    irq_pin_a: assert property (irq_r && mode_r[`MTCH_MODE_IEN]
        |-> !o_irq_n)
        else $error("interrupt pin not low");
    rx_wait_a: assert property (acc && kind == K_RX_DATA
        |=> state_r == S_RX_WAIT && !buffer_free_flag_r)
        else $error("receive task not waiting");

    tx_move_c: cover property (acc && kind == K_TX_DATA ##[1:40] last_push);
    rx_task_c: cover property (state_r == S_RX_WAIT ##1 buffer_free_flag_r);
    both_det_c: cover property (env_en_r && eop_en_r && $fell(det_r));
    stall_c: cover property (push && !fifo_ready);

endmodule : mtch_core

/* File: mtch_far_model.sv */
`timescale 1ns/1ps
module mtch_far_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic i_stall,
    output logic o_ready,
    output logic [4:0] o_count
);
    logic [7:0] mem [0:31];

    // ------------------------------------------------------------------
    // interleave side: no room while stalled, keeps bytes in order in 32 slots, then wraps and overwrites
    // ------------------------------------------------------------------
    assign o_ready = ~i_stall;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_count <= 5'h00;
        end else if (i_valid && o_ready) begin
            mem[o_count] <= i_data;
            o_count <= o_count + 5'h01;
        end
    end
endmodule : mtch_far_model

/* File: mtch_core_tb.sv */
`timescale 1ns/1ps
module mtch_core_tb;
    import mtch_pkg::*;
    logic clk, rst, env, eop, tick, rxv, rxd, stall, irq_n, ivld, irdy;
    logic tv, bo, oo, txm;
    logic [7:0] dq, rxw, rdata, idat, ctl, r;
    logic [4:0] cnt;
    mtch_bus_t bus;
    mtch_task_t tsk;
    int num_errors, check_count, i;

    mtch_core dut (.i_clk(clk), .i_reset(rst), .i_bus(bus), .o_rdata(rdata),
        .o_irq_n(irq_n), .i_env_pin(env), .i_eop_pin(eop), .i_bit_tick(tick),
        .i_dq_value(dq), .o_task(tsk), .o_task_valid(tv), .o_ilv_valid(ivld),
        .i_ilv_ready(irdy), .o_ilv_data(idat), .i_rx_wvalid(rxv),
        .i_rx_wdata(rxw), .i_rx_done(rxd), .o_bias_off(bo), .o_osc_off(oo),
        .o_tx_mode(txm), .o_control(ctl));
    mtch_far_model fm (.i_clk(clk), .i_reset(rst), .i_valid(ivld),
        .i_data(idat), .i_stall(stall), .o_ready(irdy), .o_count(cnt));

    // ------------------------------------------------------------------
    // host access tasks
    // ------------------------------------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk);
        bus.wr = 1'b1;
        bus.addr = a;
        bus.wdata = d;
        @(negedge clk);
        bus.wr = 1'b0;
    endtask : wr
    task rd(input logic [1:0] a);
        @(negedge clk);
        bus.rd = 1'b1;
        bus.addr = a;
        @(negedge clk);
        bus.rd = 1'b0;
        r = rdata;
    endtask : rd
    task rchk(input logic [1:0] a, input logic [7:0] exp);
        rd(a);
        chk(r, exp);
    endtask : rchk
    task print_verdict;
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 20000);
        num_errors++;
        print_verdict;
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        rst = 1;
        bus = '0;
        env = 0;
        eop = 0;
        tick = 0;
        stall = 0;
        rxv = 0;
        rxd = 0;
        rxw = 8'h00;
        dq = 8'hA6;
        cyc(20);
        rst = 0;
        rchk(2'h1, 8'h40);
        rchk(2'h2, 8'hA6);
        wr(2'h2, 8'h5A);
        chk(ctl, 8'h5A);
        // transmit four bytes while the interleave side is full
        wr(2'h3, 8'hC0);
        chk({7'h0, txm}, 8'h01);
        stall = 1;
        for (i = 0; i < 4; i++) wr(2'h0, 8'(8'h11 * (i + 1)));
        wr(2'h1, 8'h04);
        chk({7'h0, tv}, 8'h01);
        rchk(2'h1, 8'h00);
        chk({3'h0, tsk}, 8'h14);
        cyc(6);
        chk({7'h0, irq_n}, 8'h01);
        chk({3'h0, cnt}, 8'h00);
        stall = 0;
        i = 0;
        while (irq_n !== 1'b0 && i < 100) begin
            cyc(1);
            i++;
        end
        chk({7'h0, irq_n}, 8'h00);
        rchk(2'h1, 8'hC0);
        rchk(2'h1, 8'h40);
        chk({3'h0, cnt}, 8'h04);
        for (i = 0; i < 4; i++) chk(fm.mem[i], 8'(8'h11 * (i + 1)));
        wr(2'h1, 8'h02);
        chk({7'h0, tv}, 8'h00);
        rchk(2'h1, 8'h40);
        chk({3'h0, tsk}, 8'h14);
        wr(2'h1, 8'h06);
        chk({7'h0, tv}, 8'h01);
        rchk(2'h1, 8'h40);
        chk({3'h0, tsk}, 8'h16);
        wr(2'h1, 8'h0E);
        chk({6'h0, oo, bo}, 8'h01);
        wr(2'h1, 8'h0F);
        chk({6'h0, oo, bo}, 8'h03);
        wr(2'h1, 8'h07);
        chk({6'h0, oo, bo}, 8'h00);
        // receive single byte, decoder hands back two result bytes
        wr(2'h3, 8'h00);
        rchk(2'h1, 8'h40);
        wr(2'h1, 8'h05);
        rchk(2'h1, 8'h00);
        chk({3'h0, tsk}, 8'h05);
        @(negedge clk) begin
            rxv = 1;
            rxw = 8'hA5;
        end
        @(negedge clk) rxw = 8'h3C;
        @(negedge clk) begin
            rxv = 0;
            rxd = 1;
        end
        @(negedge clk) rxd = 0;
        rchk(2'h1, 8'hC0);
        chk({7'h0, irq_n}, 8'h01);
        rchk(2'h0, 8'hA5);
        rchk(2'h0, 8'h3C);
        // sync bytes go in before the load task; cancel rewinds pointer
        wr(2'h1, 8'h07);
        wr(2'h0, 8'h5A);
        wr(2'h0, 8'hC3);
        wr(2'h1, 8'h06);
        cyc(10);
        chk(fm.mem[4], 8'h5A);
        chk(fm.mem[5], 8'hC3);
        rd(2'h1);
        chk(r & 8'h40, 8'h40);
        // detectors in receive mode
        wr(2'h1, 8'h10);
        env = 1;
        cyc(6);
        rd(2'h1);
        chk(r & 8'h01, 8'h01);
        rchk(2'h2, 8'hA5);
        wr(2'h1, 8'h20);
        eop = 1;
        cyc(4);
        repeat (3) begin
            @(negedge clk) tick = 1;
            @(negedge clk) tick = 0;
        end
        cyc(4);
        rd(2'h1);
        chk(r & 8'h01, 8'h00);
        @(negedge clk) tick = 1;
        @(negedge clk) tick = 0;
        cyc(4);
        rd(2'h1);
        chk(r & 8'h01, 8'h01);
        wr(2'h1, 8'h30);
        cyc(4);
        rd(2'h1);
        chk(r & 8'h01, 8'h00);
        eop = 0;
        cyc(5);
        rd(2'h1);
        chk(r & 8'h81, 8'h81);
        rchk(2'h2, 8'hA5);
        env = 0;
        cyc(5);
        rd(2'h1);
        chk(r & 8'h81, 8'h80);
        wr(2'h3, 8'h40);
        rchk(2'h2, 8'hA6);
        print_verdict;
    end
endmodule : mtch_core_tb
